/* File: core/cfnf_core.sv */
/*
 * command fir smoothing and fifth notch filter with apb settings.
 * assumes command words synchronous to sys_clk, an apb master that holds
 * its request until pready, and that the command source pauses for a
 * time constant change.
 */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "cfnf_cfg.svh"

module cfnf_core import cfnf_pkg::*; #(
   parameter int HALF_TICK_CYC = `CFNF_HALF_TICK_NS / `CFNF_CLK_PERIOD_NS,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // command words from the host
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic signed [15:0] cmd_data,
   // control mode: 0 position, 1 velocity, 2 torque, 3 full-closed
   input wire logic [1:0] ctrl_mode,
   // filtered command
   output logic filt_valid,
   output logic signed [33:0] filt_data,
   output logic notch_bypass,
   // vibration suppression fine tuning widths
   output logic [9:0] vib1_width,
   output logic [9:0] vib2_width,
   output logic [9:0] vib3_width,
   output logic [9:0] vib4_width
);
   localparam logic [15:0] HALF_LAST = 16'(HALF_TICK_CYC - 1);

   cfnf_core_t q, n;
   logic signed [23:0] win_mem [0:1023];
   cfnf_stream_if #(.W(16)) cmd_s ();
   logic wrap, commit, pop, pop_nz, wr_acc, wr_tc, do_apply, pos_mode;
   logic [9:0] tgt;
   logic [11:0] wait_half;
   logic [11:0] quiet_n;
   logic signed [23:0] old_word;
   logic nv, nb;
   logic signed [33:0] ny;

   // ****************************************************************
   // input buffering and notch stage
   // ****************************************************************
   cfnf_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(sys_clk),
      .resetn(resetn),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data(cmd_data),
      .out(cmd_s.src)
   );

   cfnf_notch u_notch (
      .clk(sys_clk),
      .resetn(resetn),
      .en(q.x_valid),
      .x(q.x_data),
      .center(q.center),
      .width(q.width),
      .depth(q.depth),
      .y_valid(nv),
      .y(ny),
      .bypass(nb)
   );

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : clamp

   // effective fir length and the pulse-free wait in 0.05 ms steps
   always_comb begin
      if (!q.dof) begin
         tgt = '0;
      end else if (q.tc > `CFNF_FIR_TC_DOF_MAX) begin
         tgt = 10'(`CFNF_FIR_TC_DOF_MAX);
      end else begin
         tgt = q.tc[9:0];
      end
      if (tgt < `CFNF_WAIT_SPLIT) begin
         wait_half = {1'b0, tgt, 1'b0} + `CFNF_WAIT_PAD_HALF;
      end else begin
         wait_half = {1'b0, tgt, 1'b0}
                   + 12'((17'(tgt) * 17'(`CFNF_WAIT_LONG_MUL) + `CFNF_WAIT_LONG_RND) >> 7);
      end
   end

   // bus strobes, tick strobes and popped words
   assign wrap = (q.div == HALF_LAST);
   assign commit = wrap & q.half;
   // no word is popped in the commit cycle
   assign cmd_s.ready = !commit;
   assign pop = cmd_s.valid & cmd_s.ready;
   assign pop_nz = pop && (cmd_s.data != 16'h0000);
   assign wr_acc = psel & penable & q.pready & pwrite & !q.pslverr;
   assign wr_tc = wr_acc && (paddr == `CFNF_OFF_FIR_TC || paddr == `CFNF_OFF_TWO_DOF);
   assign pos_mode = (ctrl_mode == 2'h0) || (ctrl_mode == 2'h3);
   assign quiet_n = (q.seen | pop_nz) ? 12'h000 : ((q.quiet == 12'hFFF) ? q.quiet
                                                                      : q.quiet + 1'b1);
   assign do_apply = wrap && (q.dstate == CFNF_WAIT) && (quiet_n >= wait_half);
   // tick sum leaving the window
   assign old_word = (q.applied != '0 && q.fill >= q.applied) ? win_mem[q.wptr - q.applied]
                                                              : 24'h000000;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      n = q;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.x_valid = 1'b0;
      // notch result into the output register
      n.out_valid = nv;
      n.out_bypass = nb;
      if (nv) begin
         n.out_data = ny;
      end
      // widths only in position and full-closed modes
      for (int k = 0; k < 4; k++) begin
         n.vib_out[k] = pos_mode ? q.vib[k] : 10'h000;
      end
      // half tick divider and pulse accumulation
      n.div = wrap ? 16'h0000 : q.div + 1'b1;
      if (wrap) begin
         n.half = ~q.half;
      end
      if (pop) begin
         n.acc = q.acc + 24'($signed(cmd_s.data));
      end
      n.seen = q.seen | pop_nz;
      if (wrap) begin
         n.seen = 1'b0;
         n.quiet = quiet_n;
      end
      // one window step per 0.1 ms tick
      if (commit) begin
         n.acc = '0;
         n.wptr = q.wptr + 1'b1;
         n.fill = (q.fill == 10'h3FF) ? q.fill : q.fill + 1'b1;
         n.sum = q.sum + 34'(q.acc) - 34'(old_word);
         n.x_valid = 1'b1;
         n.x_data = (q.applied == '0) ? 34'(q.acc) : n.sum;
      end
      // switch the time constant only after the quiet time
      if (do_apply) begin
         n.applied = tgt;
         n.sum = '0;
         n.fill = '0;
         n.dstate = CFNF_IDLE;
      end
      // apb setup phase: answer and read data for the access phase
      if (psel && !penable) begin
         n.pready = 1'b1;
         case (paddr)
            `CFNF_OFF_FIR_TC: n.prdata = {18'h0, q.tc};
            `CFNF_OFF_N5_CENTER: n.prdata = {19'h0, q.center};
            `CFNF_OFF_N5_WIDTH: n.prdata = {27'h0, q.width};
            `CFNF_OFF_N5_DEPTH: n.prdata = {25'h0, q.depth};
            `CFNF_OFF_VIB1: n.prdata = {22'h0, q.vib[0]};
            `CFNF_OFF_VIB2: n.prdata = {22'h0, q.vib[1]};
            `CFNF_OFF_VIB3: n.prdata = {22'h0, q.vib[2]};
            `CFNF_OFF_VIB4: n.prdata = {22'h0, q.vib[3]};
            `CFNF_OFF_TWO_DOF: n.prdata = {31'h0, q.dof};
            `CFNF_OFF_STATUS: n.prdata = {6'h0, q.applied, 14'h0, q.out_bypass,
                                          (q.dstate == CFNF_WAIT)};
            default: begin
               n.prdata = 32'h00000000;
               n.pslverr = 1'b1;
            end
         endcase
      end
      // apb access phase writes, clamped to each setting's range except two-dof, which takes pwdata bit 0
      if (wr_acc) begin
         case (paddr)
            `CFNF_OFF_FIR_TC: n.tc = 14'(clamp(pwdata, 32'h0, `CFNF_FIR_TC_MAX));
            `CFNF_OFF_N5_CENTER: n.center = 13'(clamp(pwdata, `CFNF_N5_CENTER_MIN,
                                                      `CFNF_N5_CENTER_MAX));
            `CFNF_OFF_N5_WIDTH: n.width = 5'(clamp(pwdata, 32'h0, `CFNF_N5_WIDTH_MAX));
            `CFNF_OFF_N5_DEPTH: n.depth = 7'(clamp(pwdata, 32'h0, `CFNF_N5_DEPTH_MAX));
            `CFNF_OFF_VIB1: n.vib[0] = 10'(clamp(pwdata, 32'h0, `CFNF_VIB_MAX));
            `CFNF_OFF_VIB2: n.vib[1] = 10'(clamp(pwdata, 32'h0, `CFNF_VIB_MAX));
            `CFNF_OFF_VIB3: n.vib[2] = 10'(clamp(pwdata, 32'h0, `CFNF_VIB_MAX));
            `CFNF_OFF_VIB4: n.vib[3] = 10'(clamp(pwdata, 32'h0, `CFNF_VIB_MAX));
            `CFNF_OFF_TWO_DOF: n.dof = pwdata[0];
            default: n.dof = q.dof;
         endcase
      end
      // a new constant waits; the wait restarts from the write
      if (wr_tc) begin
         n.dstate = CFNF_WAIT;
         n.quiet = '0;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.tc <= `CFNF_FIR_TC_RST;
         q.center <= `CFNF_N5_CENTER_RST;
         q.width <= `CFNF_N5_WIDTH_RST;
         q.depth <= `CFNF_N5_DEPTH_RST;
         q.vib <= {4{`CFNF_VIB_RST}};
         q.out_bypass <= 1'b1;
         q.dstate <= CFNF_IDLE;
      end else begin
         q <= n;
      end
   end

   // fir window of per-tick pulse sums
   always_ff @(posedge sys_clk) begin
      if (commit) begin
         win_mem[q.wptr] <= q.acc;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign filt_valid = q.out_valid;
   assign filt_data = q.out_data;
   assign notch_bypass = q.out_bypass;
   assign vib1_width = q.vib_out[0];
   assign vib2_width = q.vib_out[1];
   assign vib3_width = q.vib_out[2];
   assign vib4_width = q.vib_out[3];

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // apb answer timing
   a_apb_single_ready: assert property (q.pready |=> !q.pready)
      else $error("pready held longer than one cycle");
   a_apb_answer_next: assert property ((psel && !penable) |=> q.pready)
      else $error("setup phase not answered in the next cycle");

   a_err_reads_zero: assert property (q.pslverr |-> (q.pready && q.prdata == 32'h00000000))
      else $error("error response without zero read data");

   // deferred switching of the time constant
   a_tc_write_defers: assert property (wr_tc |=> (q.dstate == CFNF_WAIT && q.quiet == 0))
      else $error("time constant write did not enter the wait");
   a_pulse_holds_wait: assert property ((pop_nz && q.dstate == CFNF_WAIT) |=>
      (q.dstate == CFNF_WAIT) [*2])
      else $error("pending constant applied right after a pulse");
   a_apply_on_tick: assert property ($changed(q.applied) |->
      $past(q.dstate == CFNF_WAIT && wrap && !q.seen && !pop_nz))
      else $error("constant applied without a quiet tick");

   a_apply_clears_sum: assert property (do_apply |=> (q.sum == 0 && q.fill == 0))
      else $error("window not cleared on switch");

   // wait time in half ticks
   a_wait_short: assert property ((tgt < 100) |-> (wait_half == 2 * tgt + 5))
      else $error("short wait time wrong");
   a_wait_long: assert property ((tgt >= 100) |->
      (wait_half * 20 >= tgt * 42 && wait_half * 20 <= tgt * 42 + 40))
      else $error("long wait time wrong");

   // fir length only with two-dof control
   a_dof_limit: assert property (q.applied <= 640)
      else $error("applied constant above limit");
   a_dof_ignored: assert property ((!q.dof && q.dstate == CFNF_IDLE) |-> q.applied == 0)
      else $error("fir active without two-dof control");

   // unfiltered path and output timing
   a_fir_pass: assert property ((commit && q.applied == 0) |=>
      (q.x_valid && q.x_data == 34'($past(q.acc))))
      else $error("unfiltered tick sum not passed");

   a_filt_after_commit: assert property (commit |-> ##3 q.out_valid)
      else $error("filtered word not issued three cycles after the tick");
   a_filt_one_cycle: assert property (q.out_valid |=> !q.out_valid)
      else $error("filtered word valid longer than one cycle");

   // settings stay inside their ranges
   a_center_range: assert property (q.center >= 50 && q.center <= 5000)
      else $error("centre out of range");
   a_width_range: assert property (q.width <= 20)
      else $error("width out of range");
   a_depth_range: assert property (q.depth <= 99)
      else $error("depth out of range");
   a_vib_range: assert property (q.vib[0] <= 1000 && q.vib[1] <= 1000 &&
      q.vib[2] <= 1000 && q.vib[3] <= 1000)
      else $error("vibration width out of range");

   // bypass flag and mode gating
   a_bypass_follows: assert property ((q.center == `CFNF_N5_BYPASS) [*2] |=>
      q.out_bypass)
      else $error("bypass flag not raised at top centre");
   a_vib_gated: assert property (!pos_mode |=> (q.vib_out == '0))
      else $error("vibration width shown outside position modes");

   // main scenarios
   c_tc_applied: cover property (do_apply && tgt != 0);
   c_tc_suspended: cover property (q.dstate == CFNF_WAIT && pop_nz);
   c_notch_bypass_left: cover property ($fell(q.out_bypass));
endmodule : cfnf_core

/* File: core/cfnf_cfg.svh */
/*
 * register offsets, reset values, setting limits and timing figures of the
 * command fir and notch filter block.
 * assumes inclusion by bare name from the core and notch design modules.
 */
`ifndef CFNF_CFG_SVH
`define CFNF_CFG_SVH

// ****************************************************************
// timing
// ****************************************************************
`define CFNF_CLK_PERIOD_NS 4
`define CFNF_HALF_TICK_NS 50000
`define CFNF_WAIT_SPLIT 10'h064
`define CFNF_WAIT_PAD_HALF 12'h005
`define CFNF_WAIT_LONG_MUL 10'h00D
`define CFNF_WAIT_LONG_RND 17'h0007F

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CFNF_OFF_FIR_TC 8'h00
`define CFNF_OFF_N5_CENTER 8'h04
`define CFNF_OFF_N5_WIDTH 8'h08
`define CFNF_OFF_N5_DEPTH 8'h0C
`define CFNF_OFF_VIB1 8'h10
`define CFNF_OFF_VIB2 8'h14
`define CFNF_OFF_VIB3 8'h18
`define CFNF_OFF_VIB4 8'h1C
`define CFNF_OFF_TWO_DOF 8'h20
`define CFNF_OFF_STATUS 8'h24

// ****************************************************************
// limits and reset values
// ****************************************************************
`define CFNF_FIR_TC_MAX 32'h00002710
`define CFNF_FIR_TC_RST 14'h000A
`define CFNF_FIR_TC_DOF_MAX 14'h0280
`define CFNF_N5_CENTER_MIN 32'h00000032
`define CFNF_N5_CENTER_MAX 32'h00001388
`define CFNF_N5_CENTER_RST 13'h1388
`define CFNF_N5_BYPASS 13'h1388
`define CFNF_N5_WIDTH_MAX 32'h00000014
`define CFNF_N5_WIDTH_RST 5'h02
`define CFNF_N5_DEPTH_MAX 32'h00000063
`define CFNF_N5_DEPTH_RST 7'h00
`define CFNF_N5_DEPTH_FULL 7'h64
`define CFNF_N5_MIX_MUL 8'h29
`define CFNF_VIB_MAX 32'h000003E8
`define CFNF_VIB_RST 10'h000

`endif

/* File: core/cfnf_pkg.sv */
/*
 * types shared by the command fir and notch filter modules.
 * assumes the cfg header for figures.
 */
package cfnf_pkg;
   // ****************************************************************
   // deferred time constant switching
   // ****************************************************************
   typedef enum logic {CFNF_IDLE, CFNF_WAIT} cfnf_defer_t;

   // ****************************************************************
   // core state
   // ****************************************************************
   typedef struct packed {
      logic [13:0] tc;
      logic [12:0] center;
      logic [4:0] width;
      logic [6:0] depth;
      logic [3:0][9:0] vib;
      logic dof;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic [15:0] div;
      logic half;
      logic seen;
      cfnf_defer_t dstate;
      logic [11:0] quiet;
      logic [9:0] applied;
      logic [9:0] fill;
      logic signed [23:0] acc;
      logic [9:0] wptr;
      logic signed [33:0] sum;
      logic x_valid;
      logic signed [33:0] x_data;
      logic out_valid;
      logic signed [33:0] out_data;
      logic out_bypass;
      logic [3:0][9:0] vib_out;
   } cfnf_core_t;

   // ****************************************************************
   // notch state
   // ****************************************************************
   typedef struct packed {
      logic [12:0] last_c;
      logic [12:0] rem;
      logic [6:0] quo;
      logic busy;
      logic [6:0] dly;
      logic [6:0] wp;
      logic [6:0] cnt;
      logic y_valid;
      logic signed [33:0] y;
      logic bypass;
   } cfnf_notch_t;
endpackage : cfnf_pkg

/* File: core/cfnf_stream_if.sv */
/*
 * valid/ready word stream between the input fifo and the filter core.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
interface cfnf_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : cfnf_stream_if

/* File: core/cfnf_fifo.sv */
/*
 * command word fifo with registered full and empty flags.
 * assumes the drain side may stall at any cycle.
 */
`timescale 1ns/10ps
module cfnf_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   cfnf_stream_if.src out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic room;
      logic avail;
   } cfnf_fifo_t;

   cfnf_fifo_t q, n;
   logic [W-1:0] mem [0:DEPTH-1];
   logic push, pop;

   // ****************************************************************
   // pointers and count
   // ****************************************************************
   assign push = in_valid & in_ready;
   assign pop = out.valid & out.ready;
   assign in_ready = q.room;
   assign out.valid = q.avail;
   assign out.data = mem[q.rp];

   // next pointer state
   always_comb begin
      n = q;
      if (push) begin
         n.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + 1'b1;
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      n.room = (n.cnt != (AW+1)'(DEPTH));
      n.avail = (n.cnt != '0);
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.room <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // storage, written on push only
   always_ff @(posedge clk) begin
      if (push) begin
         mem[q.wp] <= in_data;
      end
   end

   c_fifo_full: cover property (@(posedge clk) disable iff (!resetn) !in_ready);
endmodule : cfnf_fifo

/* File: core/cfnf_notch.sv */
/*
 * fifth notch stage: comb notch at the centre frequency, widened by two
 * taps, depth set by a blend factor, bypassed at the top setting.
 * assumes one sample per enable at 10 kHz and a centre of 50 or more.
 */
`timescale 1ns/10ps
module cfnf_notch import cfnf_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // sample in
   input wire logic en,
   input wire logic signed [33:0] x,
   // settings
   input wire logic [12:0] center,
   input wire logic [4:0] width,
   input wire logic [6:0] depth,
   // sample out
   output logic y_valid,
   output logic signed [33:0] y,
   output logic bypass
);
`include "cfnf_cfg.svh"
   cfnf_notch_t q, n;
   logic signed [33:0] mem [0:127];
   logic [6:0] half_w, i1, i2;
   logic signed [33:0] t1, t2;
   logic signed [35:0] comb_avg;
   logic [7:0] mix;
   logic signed [45:0] prod;

   // ****************************************************************
   // tap selection and blend
   // ****************************************************************
   assign half_w = {4'h0, width[4:2]};
   assign i1 = q.wp - q.dly;
   assign i2 = q.wp - q.dly - {half_w[5:0], 1'b0};
   assign t1 = (q.cnt == 7'h7F) ? mem[i1] : '0;
   assign t2 = (q.cnt == 7'h7F) ? mem[i2] : '0;
   assign mix = 8'((16'(`CFNF_N5_DEPTH_FULL - depth) * 16'(`CFNF_N5_MIX_MUL)) >> 5);

   always_comb begin
      n = q;
      comb_avg = (36'(x) + ((36'(t1) + 36'(t2)) >>> 1)) >>> 1;
      prod = 46'(comb_avg - 36'(x)) * $signed({38'h0, mix});
      n.y_valid = en;
      n.bypass = (center == `CFNF_N5_BYPASS);
      // delay length = round(5000 / centre) by repeated subtraction
      if (center != q.last_c) begin
         n.last_c = center;
         n.rem = 13'(`CFNF_N5_CENTER_MAX) + (center >> 1);
         n.quo = '0;
         n.busy = 1'b1;
      end else if (q.busy) begin
         if (q.rem >= center) begin
            n.rem = q.rem - center;
            n.quo = q.quo + 1'b1;
         end else begin
            n.busy = 1'b0;
            n.dly = q.quo;
         end
      end
      if (en) begin
         n.wp = q.wp + 1'b1;
         n.cnt = (q.cnt == 7'h7F) ? q.cnt : q.cnt + 1'b1;
         if (center == `CFNF_N5_BYPASS) begin
            n.y = x;
         end else begin
            n.y = 34'(46'(x) + (prod >>> 7));
         end
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.bypass <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // sample history
   always_ff @(posedge clk) begin
      if (en) begin
         mem[q.wp] <= x;
      end
   end

   assign y_valid = q.y_valid;
   assign y = q.y;
   assign bypass = q.bypass;

   a_notch_bypass_pass: assert property (@(posedge clk) disable iff (!resetn)
      (en && center == `CFNF_N5_BYPASS) |=> (y_valid && y == $past(x)))
      else $error("notch not bypassed at top centre setting");
   c_notch_active: cover property (@(posedge clk) disable iff (!resetn) en && !n.bypass);
endmodule : cfnf_notch

/* File: test/cfnf_host_model.sv */
/*
 * host command source: sends command words on the valid/ready stream.
 * assumes the bench calls push only while no other push runs.
 */
`timescale 1ns/10ps
module cfnf_host_model (
   // clock
   input wire logic sys_clk,
   // command words
   output logic cmd_valid,
   output logic signed [15:0] cmd_data,
   input wire logic cmd_ready
);
   // ****************************************************************
   // word source
   // ****************************************************************
   initial begin
      cmd_valid = 1'b0;
      cmd_data = 16'h0000;
   end

   // send n words, each held until the edge that takes it
   task automatic push(input int n, input logic signed [15:0] v);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_data <= v;
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         while (cmd_ready !== 1'b1) @(posedge sys_clk);
      end
      cmd_valid <= 1'b0;
      cmd_data <= ~v; // stale data not left on the line
   endtask : push
endmodule : cfnf_host_model

/* File: test/cfnf_core_tb_top.sv */
/*
 * self-checking bench of the filter core over apb.
 * assumes 8-cycle half ticks; apb waits end only on pready.
 */
`timescale 1ns/10ps
module cfnf_core_tb_top;
   // ****************************************************************
   // signals and instances
   // ****************************************************************
   localparam int HT = 8;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, cmd_valid, cmd_ready, filt_valid, notch_bypass;
   logic signed [15:0] cmd_data;
   logic [1:0] ctrl_mode = 2'h0;
   logic signed [33:0] filt_data;
   logic [9:0] vib1_width, vib2_width, vib3_width, vib4_width;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int fsum = 0;
   int f0 = 0;
   logic [31:0] r;
   logic e;

   cfnf_core #(.HALF_TICK_CYC(HT), .FIFO_DEPTH(8)) uut (.sys_clk(sys_clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data),
      .ctrl_mode(ctrl_mode), .filt_valid(filt_valid), .filt_data(filt_data),
      .notch_bypass(notch_bypass), .vib1_width(vib1_width), .vib2_width(vib2_width),
      .vib3_width(vib3_width), .vib4_width(vib4_width));
   cfnf_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
      .cmd_data(cmd_data), .cmd_ready(cmd_ready));

   // clock and hang guard
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares = miscompares + 1;
         results();
      end
   end

   // running sum of filtered words
   always @(posedge sys_clk) begin
      if (filt_valid === 1'b1) fsum <= fsum + int'(filt_data);
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
      apb(1'b0, a, 32'h00000000);
      chk(n, x, r);
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : settle

   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      settle(5);
      resetn <= 1'b1;
      rd(8'h00, 32'h0000000A, "fir_tc");
      rd(8'h04, 32'h00001388, "center");
      rd(8'h08, 32'h00000002, "width");
      rd(8'h0C, 32'h00000000, "depth");
      for (int i = 0; i < 4; i++) rd(8'h10 + 8'(4 * i), 32'h0, "vib");
      rd(8'h24, 32'h00000002, "status");
      f0 = fsum;
      host.push(4, 16'sh0005);
      settle(8 * HT);
      chk("filt_sum", 32'h00000014, fsum - f0);
      $display("test reset values done");
      // clamped writes at the range ends
      apb(1'b1, 8'h04, 32'h0000000A);
      rd(8'h04, 32'h00000032, "center_min");
      settle(3);
      chk("bypass_off", 32'h0, {31'h0, notch_bypass});
      apb(1'b1, 8'h04, 32'h00001388);
      settle(3);
      chk("bypass_on", 32'h1, {31'h0, notch_bypass});
      apb(1'b1, 8'h08, 32'h0000001F);
      rd(8'h08, 32'h00000014, "width_max");
      apb(1'b1, 8'h08, 32'h00000002);
      rd(8'h08, 32'h00000002, "width_default");
      apb(1'b1, 8'h0C, 32'h000000C8);
      rd(8'h0C, 32'h00000063, "depth_max");
      apb(1'b1, 8'h10, 32'h000007D0);
      apb(1'b1, 8'h1C, 32'h00000005);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      $display("test ranges done");
      // vibration widths shown only in position and full-closed modes
      for (int m = 0; m < 4; m++) begin
         ctrl_mode <= 2'(m);
         settle(3);
         chk("vib1", (m % 3 == 0) ? 32'h3E8 : 32'h0, {22'h0, vib1_width});
         chk("vib4", (m % 3 == 0) ? 32'h5 : 32'h0, {22'h0, vib4_width});
      end
      $display("test vibration widths done");
      // deferred switch, restarted by pulses
      apb(1'b1, 8'h20, 32'h00000001);
      apb(1'b1, 8'h00, 32'h00000014);
      settle(20 * 2 * HT);
      rd(8'h24, 32'h00000003, "pending");
      host.push(6, 16'sh0003);
      settle(20 * 2 * HT);
      rd(8'h24, 32'h00000003, "restarted");
      settle(20 * 2 * HT);
      rd(8'h24, 32'h00140002, "applied_20");
      // long constant limited in two-dof mode
      apb(1'b1, 8'h00, 32'h000003E8);
      settle(1300 * HT);
      rd(8'h24, 32'h00140003, "long_wait");
      settle(100 * HT);
      rd(8'h24, 32'h02800002, "applied_640");
      apb(1'b1, 8'h20, 32'h00000000);
      settle(10 * HT);
      rd(8'h24, 32'h00000002, "dof_off");
      $display("test time constant switching done");
      results();
   end
endmodule : cfnf_core_tb_top
